// ===== core/ddr2_cke_ctl.sv
// Purpose: host sequencer for memory clock enable and commands
// Assumes: 20 MHz clock, software orders over Avalon-MM
// Notes:   refused orders raise a sticky status flag
//
// How it works
// - power-down entry picks active or precharge kind from open banks
// - only NOP on the pins while clock enable changes for power-down
// - self refresh entry is REFRESH with clock enable low, all banks idle
// - self refresh exit raises clock enable with NOP on the pins
// - only NOP on the pins until the exit interval has passed
// - no READ until 200 clocks after self refresh exit
// - no power-down or self refresh while bursts or setup still run
// - hold clock enable for three registered edges after each change
// - leave power-down automatically before refresh is due
// - keep clock enable high during driver calibration mode
// - drive termination pin at a valid level, low in self refresh
// - mode register set only with banks idle, then wait before next
// - activate only a closed bank; precharge before another row
// - refuse any order that would give an illegal pin sequence
`timescale 1ns/100ps
`include "ddr2_ctl_regs.svh"
module ddr2_cke_ctl
	import ddr2_ctl_pkg::*;
#(
	parameter int unsigned XSNR_CYC   = 8,
	parameter int unsigned MRD_CYC    = 2,
	parameter int unsigned OP_CYC     = 8,
	parameter int unsigned PD_MAX_CYC = 150
) (
	input  wire logic        I_CLK,
	input  wire logic        I_RST_B,
	input  wire logic [3:0]  I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [31:0] I_AVS_WRITEDATA,
	input  wire logic [3:0]  I_AVS_BYTEENABLE,
	output logic [31:0]      O_AVS_READDATA,
	output logic             O_AVS_WAITREQUEST,
	output logic             O_CKE,
	output logic             O_CS_B,
	output logic             O_RAS_B,
	output logic             O_CAS_B,
	output logic             O_WE_B,
	output logic [1:0]       O_BA,
	output logic [13:0]      O_ADDR,
	output logic             O_ODT,
	output logic             O_DM
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic        req;
	logic        ack_q;
	logic        acc;
	logic        wr_ctrl;
	logic        wr_addr;
	logic        wr_stat;
	logic        cmd_wr;
	logic        go;
	logic [3:0]  code;
	logic [2:0]  ctrl_q;
	logic [13:0] addr_q;
	logic [1:0]  ba_q;
	logic [3:0]  last_cmd_q;
	logic [31:0] rd_word;
	logic [31:0] rdata_q;
	ddr_pins_t   pins_q;
	ddr_pins_t   pins_d;
	pwr_t        pwr_q;
	pwr_t        pwr_d;
	logic [3:0]  open_q;
	logic [3:0]  open_d;
	logic        legal;
	logic        exec_ok;
	logic        quiet;
	logic        ref_q;
	logic        busy;
	logic        odt_q;
	logic        dm_q;
	logic [11:0] pd_cnt_q;
	logic        auto_exit;
	logic        ld_cke;
	logic        ld_xsnr;
	logic        ld_xsrd;
	logic        ld_mrd;
	logic        ld_op;
	logic        cke_busy;
	logic        xsnr_busy;
	logic        xsrd_busy;
	logic        mrd_busy;
	logic        op_busy;

	// ------------------------------------------------------------
	// avalon slave: one wait state on every access
	// ------------------------------------------------------------
	assign req               = I_AVS_READ | I_AVS_WRITE;
	assign O_AVS_WAITREQUEST = req & ~ack_q;
	assign acc               = req & ack_q;
	assign wr_ctrl = acc & I_AVS_WRITE & (I_AVS_ADDRESS == `REG_CTRL);
	assign wr_addr = acc & I_AVS_WRITE & (I_AVS_ADDRESS == `REG_ADDR);
	assign wr_stat = acc & I_AVS_WRITE & (I_AVS_ADDRESS == `REG_STATUS);
	assign cmd_wr  = acc & I_AVS_WRITE & (I_AVS_ADDRESS == `REG_CMD)
		& I_AVS_BYTEENABLE[0];

	// ack pulses on the second cycle of a held request
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// control and address registers, byte lanes honoured
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			ctrl_q <= `CTRL_RST;
			addr_q <= `AD_RST;
			ba_q   <= `BA_RST;
		end else begin
			if (wr_ctrl && I_AVS_BYTEENABLE[0]) begin
				ctrl_q <= I_AVS_WRITEDATA[`CTRL_DM_BIT:0];
			end
			if (wr_addr && I_AVS_BYTEENABLE[0]) begin
				addr_q[7:0] <= I_AVS_WRITEDATA[7:0];
			end
			if (wr_addr && I_AVS_BYTEENABLE[1]) begin
				addr_q[`AD_ROW_MSB:8] <= I_AVS_WRITEDATA[`AD_ROW_MSB:8];
			end
			if (wr_addr && I_AVS_BYTEENABLE[2]) begin
				ba_q <= I_AVS_WRITEDATA[`AD_BA_MSB:`AD_BA_LSB];
			end
		end
	end

	// read mux; unmapped offsets read as zero
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (I_AVS_ADDRESS)
			`REG_CTRL:   rd_word = {29'h0, ctrl_q};
			`REG_ADDR:   rd_word = {14'h0, ba_q, 2'h0, addr_q};
			`REG_CMD:    rd_word = {28'h0, last_cmd_q};
			`REG_STATUS: rd_word = {21'h0, pins_q.cke, ref_q, busy,
				open_q, 2'h0, pwr_q};
			default:     rd_word = 32'h0000_0000;
		endcase
	end

	// read data captured the cycle before the ack edge
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rdata_q <= 32'h0000_0000;
		end else if (I_AVS_READ && !ack_q) begin
			rdata_q <= rd_word;
		end
	end
	assign O_AVS_READDATA = rdata_q;

	// ------------------------------------------------------------
	// interval timers
	// ------------------------------------------------------------
	ddr2_cyc_timer #(.W(8)) u_cke_t (.i_clk(I_CLK), .i_rst_b(I_RST_B),
		.i_load(ld_cke), .i_count(`TCKE_CYC), .o_busy(cke_busy));
	ddr2_cyc_timer #(.W(8)) u_xsnr_t (.i_clk(I_CLK), .i_rst_b(I_RST_B),
		.i_load(ld_xsnr), .i_count(8'(XSNR_CYC)), .o_busy(xsnr_busy));
	ddr2_cyc_timer #(.W(8)) u_xsrd_t (.i_clk(I_CLK), .i_rst_b(I_RST_B),
		.i_load(ld_xsrd), .i_count(`TXSRD_CYC), .o_busy(xsrd_busy));
	ddr2_cyc_timer #(.W(8)) u_mrd_t (.i_clk(I_CLK), .i_rst_b(I_RST_B),
		.i_load(ld_mrd), .i_count(8'(MRD_CYC)), .o_busy(mrd_busy));
	ddr2_cyc_timer #(.W(8)) u_op_t (.i_clk(I_CLK), .i_rst_b(I_RST_B),
		.i_load(ld_op), .i_count(8'(OP_CYC)), .o_busy(op_busy));

	assign busy = cke_busy | xsnr_busy | mrd_busy | op_busy;

	// forced exit - no refresh happens in power-down
	assign auto_exit = ((pwr_q == PS_ACT_PD) || (pwr_q == PS_PRE_PD))
		&& (pd_cnt_q >= 12'(PD_MAX_CYC)) && !cke_busy;
	assign go   = cmd_wr | auto_exit;
	assign code = cmd_wr ? I_AVS_WRITEDATA[`CMD_FIELD_MSB:0] : `CMD_PDX;

	// ------------------------------------------------------------
	// order decode: legality and next pin state
	// ------------------------------------------------------------
	always_comb begin
		legal   = 1'b0;
		pwr_d   = pwr_q;
		open_d  = open_q;
		ld_cke  = 1'b0;
		ld_xsnr = 1'b0;
		ld_xsrd = 1'b0;
		ld_mrd  = 1'b0;
		ld_op   = 1'b0;
		// idle pins - NOP starts nothing
		pins_d  = '{cke: pins_q.cke, cmd: `PIN_NOP, ba: pins_q.ba,
			addr: pins_q.addr};
		// exit interval - nothing executable yet
		exec_ok = (pwr_q == PS_STANDBY) && !xsnr_busy && !mrd_busy;
		// quiet check - no burst, setup or cke hold pending
		// calibration guard - keeps clock enable high
		quiet   = !op_busy && !mrd_busy && !cke_busy && !xsnr_busy
			&& !ctrl_q[`CTRL_OCD_BIT] && (pwr_q == PS_STANDBY);
		if (go) begin
			// refusal default - unknown orders do nothing
			unique case (code)
				`CMD_NOP: begin
					legal = 1'b1;
				end
				// mode load - bank picks register
				// mode set guard - idle banks, then wait
				`CMD_MRS: begin
					if (exec_ok && open_q == `NO_BANKS && !op_busy) begin
						legal       = 1'b1;
						pins_d.cmd  = `PIN_MRS;
						pins_d.ba   = ba_q;
						pins_d.addr = addr_q;
						ld_mrd      = 1'b1;
					end
				end
				// activate guard - bank must be closed
				`CMD_ACT: begin
					if (exec_ok && !open_q[ba_q]) begin
						legal          = 1'b1;
						pins_d.cmd     = `PIN_ACT;
						pins_d.ba      = ba_q;
						pins_d.addr    = addr_q;
						open_d[ba_q]   = 1'b1;
					end
				end
				// read fields - column and A10 flag
				// read delay after self refresh exit
				// early column - no activate wait here
				`CMD_RD, `CMD_RDA, `CMD_WR, `CMD_WRA: begin
					if (exec_ok && open_q[ba_q] && !(xsrd_busy &&
						(code == `CMD_RD || code == `CMD_RDA))) begin
						legal       = 1'b1;
						pins_d.cmd  = (code == `CMD_RD || code == `CMD_RDA)
							? `PIN_RD : `PIN_WR;
						pins_d.ba   = ba_q;
						pins_d.addr = `AD_RST;
						pins_d.addr[`AD_COL_MSB:0] = addr_q[`AD_COL_MSB:0];
						pins_d.addr[`AD_AP_BIT] =
							(code == `CMD_RDA) || (code == `CMD_WRA);
						// auto precharge - row counts closed
						if (pins_d.addr[`AD_AP_BIT]) begin
							open_d[ba_q] = 1'b0;
						end
						ld_op = 1'b1;
					end
				end
				`CMD_PRE, `CMD_PREA: begin
					if (exec_ok) begin
						legal       = 1'b1;
						pins_d.cmd  = `PIN_PRE;
						pins_d.ba   = ba_q;
						pins_d.addr = `AD_RST;
						pins_d.addr[`AD_AP_BIT] = (code == `CMD_PREA);
						if (code == `CMD_PREA) begin
							open_d = `NO_BANKS;
						end else begin
							open_d[ba_q] = 1'b0;
						end
						ld_op = 1'b1;
					end
				end
				`CMD_REF: begin
					if (exec_ok && open_q == `NO_BANKS && !op_busy) begin
						legal      = 1'b1;
						pins_d.cmd = `PIN_REF;
						ld_op      = 1'b1;
					end
				end
				`CMD_PDE: begin
					if (quiet) begin
						legal      = 1'b1;
						pins_d.cke = 1'b0;
						pwr_d      = (open_q != `NO_BANKS)
							? PS_ACT_PD : PS_PRE_PD;
						ld_cke     = 1'b1;
					end
				end
				// cke hold - no change before three edges
				`CMD_PDX: begin
					if ((pwr_q == PS_ACT_PD || pwr_q == PS_PRE_PD)
						&& !cke_busy) begin
						legal      = 1'b1;
						pins_d.cke = 1'b1;
						pwr_d      = PS_STANDBY;
						ld_cke     = 1'b1;
					end
				end
				// self refresh entry - idle banks, REF, cke low
				`CMD_SRE: begin
					if (quiet && open_q == `NO_BANKS) begin
						legal      = 1'b1;
						pins_d.cke = 1'b0;
						pins_d.cmd = `PIN_REF;
						pwr_d      = PS_SELF_REF;
						ld_cke     = 1'b1;
					end
				end
				// exit with NOP on the pins
				// exit taken as done once cke rises
				`CMD_SRX: begin
					if (pwr_q == PS_SELF_REF && !cke_busy) begin
						legal      = 1'b1;
						pins_d.cke = 1'b1;
						pwr_d      = PS_STANDBY;
						ld_cke     = 1'b1;
						ld_xsnr    = 1'b1;
						ld_xsrd    = 1'b1;
					end
				end
				default: begin
					legal = 1'b0;
				end
			endcase
		end
		if (!legal) begin
			pwr_d  = pwr_q;
			open_d = open_q;
		end
	end

	// pins registered - all change after the edge
	// power mirror - follows the cke edge pair
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			pins_q <= '{cke: 1'b1, cmd: `PIN_NOP, ba: `BA_RST,
				addr: `AD_RST};
			pwr_q  <= PS_STANDBY;
			open_q <= `NO_BANKS;
		end else begin
			pins_q <= pins_d;
			pwr_q  <= pwr_d;
			open_q <= open_d;
		end
	end

	// last order and sticky refusal; a new refusal beats the clear
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			last_cmd_q <= `CMD_NOP;
			ref_q      <= 1'b0;
		end else begin
			if (cmd_wr) begin
				last_cmd_q <= code;
			end
			if (cmd_wr && !legal) begin
				ref_q <= 1'b1;
			end else if (wr_stat && I_AVS_BYTEENABLE[1]
				&& I_AVS_WRITEDATA[`STAT_REFUSED_BIT]) begin
				ref_q <= 1'b0;
			end
		end
	end

	// power-down dwell counter, saturating
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			pd_cnt_q <= 12'h000;
		end else if (pwr_q == PS_ACT_PD || pwr_q == PS_PRE_PD) begin
			if (pd_cnt_q != 12'hFFF) begin
				pd_cnt_q <= pd_cnt_q + 12'h001;
			end
		end else begin
			pd_cnt_q <= 12'h000;
		end
	end

	// termination level - always driven, off in self refresh
	// write mask - high level inhibits byte writes
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			odt_q <= 1'b0;
			dm_q  <= 1'b0;
		end else begin
			odt_q <= ctrl_q[`CTRL_ODT_BIT] && (pwr_d != PS_SELF_REF);
			dm_q  <= ctrl_q[`CTRL_DM_BIT];
		end
	end

	// deselect unused - controller always selects
	assign O_CKE   = pins_q.cke;
	assign O_CS_B  = pins_q.cmd[3];
	assign O_RAS_B = pins_q.cmd[2];
	assign O_CAS_B = pins_q.cmd[1];
	assign O_WE_B  = pins_q.cmd[0];
	assign O_BA    = pins_q.ba;
	assign O_ADDR  = pins_q.addr;
	assign O_ODT   = odt_q;
	assign O_DM    = dm_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	logic [7:0] since_q;
	logic [3:0] ba_hot;
	assign ba_hot = 4'h1 << pins_q.ba;

	// cycles since self refresh exit, saturating
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			since_q <= 8'hFF;
		end else if (pwr_q == PS_SELF_REF && pwr_d == PS_STANDBY) begin
			since_q <= 8'h01;
		end else if (since_q != 8'hFF) begin
			since_q <= since_q + 8'h01;
		end
	end

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);

	sequence s_sr_entry;
		$fell(pins_q.cke) && pins_q.cmd == `PIN_REF;
	endsequence
	sequence s_cke_move;
		$changed(pins_q.cke);
	endsequence

	a_cke_move_nop: assert property (s_cke_move |->
		pins_q.cmd == `PIN_NOP || (!pins_q.cke && pins_q.cmd == `PIN_REF))
		else $error("command other than NOP at clock enable change");
	a_cke_hold_three: assert property (
		s_cke_move |=> $stable(pins_q.cke)[*3])
		else $error("clock enable changed within three edges");
	a_sr_entry_idle: assert property (
		s_sr_entry |-> $past(open_q) == `NO_BANKS)
		else $error("self refresh entered with an open bank");
	a_exit_nop_only: assert property (xsnr_busy |->
		pins_q.cmd == `PIN_NOP)
		else $error("command issued inside self refresh exit interval");
	a_read_after_exit: assert property (
		pins_q.cmd == `PIN_RD |-> since_q > `TXSRD_CYC)
		else $error("read too soon after self refresh exit");
	a_act_closed_bank: assert property (
		pins_q.cmd == `PIN_ACT |-> ($past(open_q) & ba_hot) == `NO_BANKS)
		else $error("activate to a bank with an open row");
	a_mrs_idle_banks: assert property (
		pins_q.cmd == `PIN_MRS |-> $past(open_q) == `NO_BANKS
		##1 (pins_q.cmd == `PIN_NOP))
		else $error("mode set with open bank or no wait after");
	a_pd_entry_quiet: assert property (
		$fell(pins_q.cke) |-> !$past(op_busy) && !$past(mrd_busy))
		else $error("power-down entered while an operation runs");
	a_ocd_keeps_cke: assert property (
		$past(ctrl_q[`CTRL_OCD_BIT]) && $past(pins_q.cke) |-> pins_q.cke)
		else $error("clock enable dropped in calibration mode");
	a_pd_mirror_cke: assert property (
		pwr_q != PS_STANDBY |-> !pins_q.cke)
		else $error("power state disagrees with clock enable");
	a_pd_dwell_bound: assert property (
		pd_cnt_q <= 12'(PD_MAX_CYC + 4))
		else $error("power-down held past the refresh bound");
	a_odt_off_sr: assert property (
		pwr_q == PS_SELF_REF |-> !O_ODT)
		else $error("termination driven high in self refresh");

endmodule

// ===== shared/ddr2_ctl_regs.svh
// Purpose: register offsets, fields, command codes and counts
// Assumes: byte addresses on a 32-bit Avalon-MM slave
// Notes:   definitions only, included by bare name
`ifndef DDR2_CTL_REGS_SVH
`define DDR2_CTL_REGS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define REG_CTRL          4'h0
`define REG_ADDR          4'h4
`define REG_CMD           4'h8
`define REG_STATUS        4'hC

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define CTRL_ODT_BIT      0
`define CTRL_OCD_BIT      1
`define CTRL_DM_BIT       2
`define CTRL_RST          3'h0
`define AD_COL_MSB        9
`define AD_AP_BIT         10
`define AD_ROW_MSB        13
`define AD_BA_LSB         16
`define AD_BA_MSB         17
`define AD_RST            14'h0000
`define BA_RST            2'h0
`define CMD_FIELD_MSB     3
`define STAT_REFUSED_BIT  9

// ------------------------------------------------------------
// software command codes
// ------------------------------------------------------------
`define CMD_NOP           4'h0
`define CMD_MRS           4'h1
`define CMD_ACT           4'h2
`define CMD_RD            4'h3
`define CMD_RDA           4'h4
`define CMD_WR            4'h5
`define CMD_WRA           4'h6
`define CMD_PRE           4'h7
`define CMD_PREA          4'h8
`define CMD_REF           4'h9
`define CMD_PDE           4'hA
`define CMD_PDX           4'hB
`define CMD_SRE           4'hC
`define CMD_SRX           4'hD

// ------------------------------------------------------------
// pin codes {cs_b, ras_b, cas_b, we_b}
// ------------------------------------------------------------
`define PIN_MRS           4'h0
`define PIN_REF           4'h1
`define PIN_PRE           4'h2
`define PIN_ACT           4'h3
`define PIN_WR            4'h4
`define PIN_RD            4'h5
`define PIN_NOP           4'h7

// ------------------------------------------------------------
// timing counts in clocks and the empty bank mask
// ------------------------------------------------------------
`define TCKE_CYC          8'h03
`define TXSRD_CYC         8'hC8
`define NO_BANKS          4'h0

`endif

// ===== shared/ddr2_ctl_pkg.sv
// Purpose: types shared by the controller files
// Assumes: nothing
// Notes:   constants live in ddr2_ctl_regs.svh
package ddr2_ctl_pkg;

	// ------------------------------------------------------------
	// power state mirrored from the memory
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PS_STANDBY,
		PS_ACT_PD,
		PS_PRE_PD,
		PS_SELF_REF
	} pwr_t;

	// ------------------------------------------------------------
	// command pin bundle driven each rising edge
	// ------------------------------------------------------------
	typedef struct packed {
		logic        cke;
		logic [3:0]  cmd;
		logic [1:0]  ba;
		logic [13:0] addr;
	} ddr_pins_t;

endpackage

// ===== core/ddr2_cyc_timer.sv
// Purpose: loadable down counter, busy while non-zero
// Assumes: load value fits in W bits
// Notes:   busy for exactly i_count cycles after the load edge
`timescale 1ns/100ps
module ddr2_cyc_timer #(
	parameter int W = 8
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_b,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_count,
	output logic              o_busy
);

	logic [W-1:0] cnt_q;

	// load wins over the countdown
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_q <= '0;
		end else if (i_load) begin
			cnt_q <= i_count;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign o_busy = (cnt_q != '0);

endmodule

// ===== sim/ddr2_mem_model.sv
// Purpose: behavioural memory seen through its command pins
// Assumes: pins change just after the rising edge
// Notes:   o_bad counts sequences the memory would not accept
`timescale 1ns/100ps
`include "ddr2_ctl_regs.svh"
module ddr2_mem_model
	import ddr2_ctl_pkg::*;
#(
	parameter int XSNR = 2
) (
	input  wire logic        i_clk,
	input  wire logic        i_cke,
	input  wire logic [3:0]  i_cmd,
	input  wire logic [1:0]  i_ba,
	input  wire logic [13:0] i_addr,
	output pwr_t             o_state,
	output logic [3:0]       o_open,
	output int               o_bad
);
	pwr_t        state_q = PS_STANDBY;
	logic [3:0]  open_q = 4'h0;
	int          bad_q = 0;
	logic        cke_q = 1'b1;
	logic [1:0]  hold_q = 2'h3;
	logic [7:0]  srx_q = 8'hFF;
	logic [13:0] mode_q [4];
	assign o_state = state_q;
	assign o_open = open_q;
	assign o_bad = bad_q;

	// ----------------------------------------
	// decode per edge
	// ----------------------------------------
	// no reset pin, so state starts idle like a freshly set-up part
	always @(posedge i_clk) begin
		cke_q <= i_cke;
		hold_q <= (i_cke != cke_q) ? 2'h1 : hold_q + 2'(hold_q != 2'h3);
		srx_q <= srx_q + 8'(srx_q != 8'hFF);
		if (i_cke != cke_q && hold_q != 2'h3)
			bad_q <= bad_q + 1;
		if (!cke_q && i_cke) begin
			if (state_q == PS_SELF_REF)
				srx_q <= 8'h01;
			state_q <= PS_STANDBY;
			if (i_cmd != `PIN_NOP)
				bad_q <= bad_q + 1;
		end else if (cke_q && !i_cke) begin
			// self refresh from all banks idle
			if (i_cmd == `PIN_REF && open_q == 4'h0)
				state_q <= PS_SELF_REF;
			else if (i_cmd == `PIN_NOP)
				state_q <= (open_q != 4'h0) ? PS_ACT_PD : PS_PRE_PD;
			else
				bad_q <= bad_q + 1;
		end else if (cke_q) begin
			if ((i_cmd != `PIN_NOP && srx_q < 8'(XSNR))
				|| (i_cmd == `PIN_RD && srx_q < `TXSRD_CYC))
				bad_q <= bad_q + 1;
			case (i_cmd)
			`PIN_MRS: begin
				mode_q[i_ba] <= i_addr;
				if (open_q != 4'h0)
					bad_q <= bad_q + 1;
			end
			`PIN_ACT: begin
				if (open_q[i_ba])
					bad_q <= bad_q + 1;
				open_q[i_ba] <= 1'b1;
			end
			`PIN_RD, `PIN_WR: begin
				if (!open_q[i_ba])
					bad_q <= bad_q + 1;
				if (i_addr[`AD_AP_BIT])
					open_q[i_ba] <= 1'b0;
			end
			`PIN_PRE: begin
				if (i_addr[`AD_AP_BIT])
					open_q <= 4'h0;
				else
					open_q[i_ba] <= 1'b0;
			end
			default: ;
			endcase
		end
	end
endmodule

// ===== sim/test_ddr2_cke_ctl.sv
// Purpose: self-checking run of the clock-enable sequencer
// Assumes: counts shortened through parameters
// Notes:   integer model predicts every status read
`timescale 1ns/100ps
`include "ddr2_ctl_regs.svh"
module test_ddr2_cke_ctl
	import ddr2_ctl_pkg::*;
;
	localparam int PD_MAX = 40;
	logic        clk = 1'b0;
	logic        rst_b = 1'b1;
	logic [3:0]  avs_addr = 4'h0;
	logic        avs_rd = 1'b0;
	logic        avs_wr = 1'b0;
	logic [31:0] avs_wdata = 32'h0000_0000;
	logic [3:0]  avs_be = 4'hF;
	logic [31:0] avs_rdata, q, ctl, e;
	logic        avs_wait, cke, odt, dm;
	logic [3:0]  pin, m_open;
	logic [1:0]  ba;
	logic [13:0] addr;
	pwr_t        m_state;
	int          m_bad, n_fail = 0, n_compared = 0, cyc = 0, t = 0;
	int          seed = 35336, wild = 0, st = 0, open = 0, srx = -1000;

	ddr2_cke_ctl #(.XSNR_CYC(2), .MRD_CYC(1), .OP_CYC(2), .PD_MAX_CYC(PD_MAX))
	u_ddr2_cke_ctl (.I_CLK(clk), .I_RST_B(rst_b), .I_AVS_ADDRESS(avs_addr),
		.I_AVS_READ(avs_rd), .I_AVS_WRITE(avs_wr), .I_AVS_WRITEDATA(avs_wdata),
		.I_AVS_BYTEENABLE(avs_be), .O_AVS_READDATA(avs_rdata),
		.O_AVS_WAITREQUEST(avs_wait), .O_CKE(cke), .O_CS_B(pin[3]),
		.O_RAS_B(pin[2]), .O_CAS_B(pin[1]), .O_WE_B(pin[0]), .O_BA(ba),
		.O_ADDR(addr), .O_ODT(odt), .O_DM(dm));
	ddr2_mem_model #(.XSNR(2)) u_ddr2_mem_model (.i_clk(clk), .i_cke(cke),
		.i_cmd(pin), .i_ba(ba), .i_addr(addr), .o_state(m_state),
		.o_open(m_open), .o_bad(m_bad));

	always #25 clk = ~clk;
	// hang guard, run needs about 3300 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// request held until waitrequest low at a rising edge
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] be);
		@(posedge clk);
		avs_rd <= !w;
		avs_wr <= w;
		avs_addr <= a;
		avs_wdata <= d;
		avs_be <= be;
		// waitrequest and read data taken at the same rising edge
		do @(posedge clk); while (avs_wait !== 1'b0);
		t = cyc;
		q = avs_rdata;
		avs_rd <= 1'b0;
		avs_wr <= 1'b0;
	endtask

	// one order, predicted refusal and state, then flag cleared
	task automatic order(input int c, input int b);
		int ok;
		ctl = 32'($random(seed)) & 32'h0000_0005;
		ctl[1] = wild != 0 && st == 0 && ($random(seed) & 7) == 0;
		bus(1'b1, `REG_CTRL, ctl, 4'hF);
		bus(1'b1, `REG_ADDR, {14'h0, 2'(b), 2'h0, 14'($random(seed))}, 4'hF);
		bus(1'b1, `REG_CMD, 32'(c), 4'hF);
		ok = c < 14 && (st == 0 || c == 0);
		case (c)
		1, 9: ok = ok && open == 0;
		2: ok = ok && !open[b];
		3, 4: ok = ok && open[b] && t - srx >= 201;
		5, 6: ok = ok && open[b];
		10: ok = ok && !ctl[1];
		11: ok = st == 1 || st == 2;
		12: ok = ok && open == 0 && !ctl[1];
		13: ok = st == 3;
		default: ;
		endcase
		if (ok)
			case (c)
			2: open[b] = 1'b1;
			4, 6, 7: open[b] = 1'b0;
			8: open = 0;
			10: st = open != 0 ? 1 : 2;
			11: st = 0;
			12: st = 3;
			13: begin
				st = 0;
				srx = t;
			end
			default: ;
			endcase
		repeat (2) @(posedge clk);
		bus(1'b0, `REG_STATUS, 32'h0, 4'hF);
		e = {21'h0, st == 0, !ok, 1'b0, 4'(open), 2'h0, 2'(st)};
		chk("status", q & 32'h0000_06F3, e);
		chk("odt dm", {odt, dm}, {ctl[0] && st != 3, ctl[2]});
		chk("model", {m_state, m_open}, {2'(st), 4'(open)});
		bus(1'b1, `REG_STATUS, 32'h0000_0200, 4'h2);
	endtask

	initial begin
		rst_b <= 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		bus(1'b0, `REG_STATUS, 32'h0, 4'hF);
		chk("reset status", q, 32'h0000_0400);
		bus(1'b0, 4'h2, 32'h0, 4'hF);
		chk("unmapped", q, 32'h0);
		$display("test reset done");
		order(8, 1);
		order(12, 1);
		order(3, 1);
		order(13, 1);
		order(2, 1);
		order(3, 1);
		repeat (200) @(posedge clk);
		order(3, 1);
		order(4, 1);
		$display("test self refresh done");
		wild = 1;
		repeat (150) begin
			order(st == 3 && $random(seed) % 2 ? 13 : $random(seed) & 15,
				$random(seed) & 3);
			if (st == 1 || st == 2) begin
				if ($random(seed) & 1)
					order(11, 0);
				else begin
					repeat (PD_MAX + 20) @(posedge clk);
					st = 0;
					order(0, 0);
				end
			end
		end
		$display("test random done");
		chk("pin sequences", m_bad, 32'h0);
		print_verdict();
	end
endmodule
